// ==== shared/fcr_pkg.sv ====
package fcr_pkg;
	// ***************************************************
	// register map (byte addresses, 32-bit words)
	// ***************************************************
	localparam int FCR_AW = 8;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_CMD = 8'h08;
	localparam logic [7:0] ADDR_ISTS = 8'h0c;
	localparam logic [7:0] ADDR_IMSK = 8'h10;

	// configuration field positions and reset value
	localparam int CFG_IRQEN_BIT = 7;
	localparam int CFG_PEND_BIT = 5;
	localparam int CFG_SUPP_BIT = 4;
	localparam int CFG_WS_LSB = 2;
	localparam int CFG_FDF_BIT = 1;
	localparam int CFG_FSF_BIT = 0;
	localparam logic [7:0] CFG_RESET = 8'h00;

	// command/status word and interrupt event bits
	localparam int CMD_DONE_BIT = 7;
	localparam int CMD_ACK_BIT = 0;
	localparam int EV_CMD_DONE = 0;
	localparam int EV_SINGLE = 1;
	localparam int EV_DOUBLE = 2;
	localparam int EV_ERASE_DONE = 3;
	localparam int EV_N = 4;
	localparam logic [EV_N-1:0] IMSK_RESET = 4'h0;

	// wait-state codes and the maximum wait count
	localparam logic [1:0] WS_MAX = 2'h0;
	localparam logic [1:0] WS_OFF = 2'h3;
	localparam int WS_MAX_CYCLES = 1;
	localparam logic [1:0] SEC_UNSECURE = 2'h2;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_ERASE = 2'h1, ST_VERIFY = 2'h2,
		ST_PROG = 2'h3} fcr_state_t;
	typedef enum logic [1:0] {OP_NONE = 2'h0, OP_ERASE_ALL = 2'h1, OP_VERIFY = 2'h2,
		OP_PROG_SEC = 2'h3} fcr_op_t;

	// true for every mapped register word
	function automatic logic fcr_addr_hit(input logic [FCR_AW-1:0] a);
		return (a == ADDR_CFG) || (a == ADDR_CMD) || (a == ADDR_ISTS) || (a == ADDR_IMSK);
	endfunction : fcr_addr_hit
endpackage : fcr_pkg

// ==== rtl/fcr_axil_slave.sv ====
module fcr_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [fcr_pkg::FCR_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [fcr_pkg::FCR_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_stb,
	output logic [fcr_pkg::FCR_AW-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic [31:0] rd_data
);
	import fcr_pkg::*;

	logic aw_rdy_q, aw_rdy_d, w_rdy_q, w_rdy_d, ar_rdy_q, ar_rdy_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [FCR_AW-1:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0] wstrb_q, wstrb_d;

	// a write is performed once both halves are held and no answer is pending
	assign wr_stb = !aw_rdy_q && !w_rdy_q && !bvalid_q;
	assign wr_addr = awaddr_q;
	assign wr_data = wdata_q;
	assign wr_strb = wstrb_q;

	// next-state of both channel pairs
	always_comb begin
		{aw_rdy_d, w_rdy_d, ar_rdy_d} = {aw_rdy_q, w_rdy_q, ar_rdy_q};
		{awaddr_d, wdata_d, wstrb_d} = {awaddr_q, wdata_q, wstrb_q};
		{bvalid_d, bresp_d, rvalid_d, rresp_d, rdata_d} =
			{bvalid_q, bresp_q, rvalid_q, rresp_q, rdata_q};
		if (s_axi_awvalid && aw_rdy_q) begin
			aw_rdy_d = 1'b0;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && w_rdy_q) begin
			w_rdy_d = 1'b0;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (wr_stb) begin
			bvalid_d = 1'b1;
			bresp_d = fcr_addr_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			aw_rdy_d = 1'b1;
			w_rdy_d = 1'b1;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		// read data are taken from the decode in the cycle the address is accepted
		if (s_axi_arvalid && ar_rdy_q) begin
			ar_rdy_d = 1'b0;
			rvalid_d = 1'b1;
			rdata_d = rd_data;
			rresp_d = fcr_addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
			ar_rdy_d = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{aw_rdy_q, w_rdy_q, ar_rdy_q} <= 3'h7;
			{bvalid_q, rvalid_q} <= 2'h0;
			{bresp_q, rresp_q} <= 4'h0;
			awaddr_q <= '0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			rdata_q <= 32'h0;
		end else begin
			{aw_rdy_q, w_rdy_q, ar_rdy_q} <= {aw_rdy_d, w_rdy_d, ar_rdy_d};
			{bvalid_q, rvalid_q} <= {bvalid_d, rvalid_d};
			{bresp_q, rresp_q} <= {bresp_d, rresp_d};
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			rdata_q <= rdata_d;
		end
	end

	assign {s_axi_awready, s_axi_wready, s_axi_arready} = {aw_rdy_q, w_rdy_q, ar_rdy_q};
	assign {s_axi_bvalid, s_axi_bresp} = {bvalid_q, bresp_q};
	assign {s_axi_rvalid, s_axi_rresp, s_axi_rdata} = {rvalid_q, rresp_q, rdata_q};
endmodule : fcr_axil_slave

// ==== rtl/fcr_read_ws.sv ====
module fcr_read_ws #(
	parameter int MAX_WAIT = fcr_pkg::WS_MAX_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] ws_code,
	input wire logic ws_write,
	input wire logic rd_start,
	input wire logic ecc_single,
	input wire logic ecc_double,
	input wire logic suppress_single_fault,
	input wire logic force_single_fault,
	input wire logic force_double_fault,
	output logic rd_done,
	output logic wait_switch_ack,
	output logic single_rep,
	output logic double_rep
);
	import fcr_pkg::*;

	if (MAX_WAIT < 1 || MAX_WAIT > 15) begin : g_chk
		$error("MAX_WAIT must lie in 1..15");
	end

	logic busy_q, busy_d, pend_q, pend_d, done_q, done_d, sf_q, sf_d, df_q, df_d;
	logic [3:0] cnt_q, cnt_d;
	logic [1:0] act_q, act_d;

	// reads run on the adopted code; a new code is adopted only between reads
	always_comb begin
		{busy_d, cnt_d, act_d, pend_d} = {busy_q, cnt_q, act_q, pend_q};
		{done_d, sf_d, df_d} = 3'h0;
		if (!busy_q && rd_start) begin
			busy_d = 1'b1;
			cnt_d = (act_q == WS_OFF) ? 4'h0 : 4'(MAX_WAIT);
		end else if (busy_q && cnt_q != 4'h0) begin
			cnt_d = cnt_q - 4'h1;
		end else if (busy_q) begin
			busy_d = 1'b0;
			done_d = 1'b1;
			sf_d = (ecc_single || force_single_fault) && !suppress_single_fault;
			df_d = ecc_double || force_double_fault;
		end else if (pend_q) begin
			act_d = ws_code;
			pend_d = 1'b0;
		end
		if (ws_write) begin
			pend_d = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{busy_q, pend_q, done_q, sf_q, df_q} <= 5'h0;
			cnt_q <= 4'h0;
			act_q <= WS_MAX;
		end else begin
			{busy_q, pend_q, done_q, sf_q, df_q} <= {busy_d, pend_d, done_d, sf_d, df_d};
			cnt_q <= cnt_d;
			act_q <= act_d;
		end
	end

	assign {rd_done, single_rep, double_rep} = {done_q, sf_q, df_q};
	assign wait_switch_ack = !pend_q;

	ws_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(rd_start && !busy_q && act_q == WS_OFF) |=> ##1 done_q)
		else $error("disabled wait-states read not done in two cycles");
endmodule : fcr_read_ws

// ==== rtl/fcr_top.sv ====
module fcr_top #(
	parameter int MAX_WAIT = fcr_pkg::WS_MAX_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [fcr_pkg::FCR_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [fcr_pkg::FCR_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cmd_done_flag,
	input wire logic erase_all_req,
	input wire logic mc_step_done,
	input wire logic rd_start,
	input wire logic ecc_single,
	input wire logic ecc_double,
	input wire logic single_fault_irq_enable,
	output logic irq,
	output logic cmd_launch,
	output logic mc_op_start,
	output fcr_pkg::fcr_op_t mc_op_code,
	output logic sec_force_unsecure,
	output logic rd_done,
	output logic single_fault_set,
	output logic double_fault_set
);
	import fcr_pkg::*;

	// ***************************************************
	// bus slave and read path
	// ***************************************************
	logic wr_stb;
	logic [FCR_AW-1:0] wr_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	logic wait_switch_ack;

	fcr_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_stb(wr_stb),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.rd_data(rd_data)
	);

	// configuration fields
	logic irq_en_q, irq_en_d, supp_q, supp_d, fdf_q, fdf_d, fsf_q, fsf_d;
	logic [1:0] ws_q, ws_d;
	logic ws_wr;

	fcr_read_ws #(
		.MAX_WAIT(MAX_WAIT)
	) u_rd (
		.aclk(aclk),
		.aresetn(aresetn),
		.ws_code(ws_q),
		.ws_write(ws_wr),
		.rd_start(rd_start),
		.ecc_single(ecc_single),
		.ecc_double(ecc_double),
		.suppress_single_fault(supp_q),
		.force_single_fault(fsf_q),
		.force_double_fault(fdf_q),
		.rd_done(rd_done),
		.wait_switch_ack(wait_switch_ack),
		.single_rep(single_fault_set),
		.double_rep(double_fault_set)
	);

	// ***************************************************
	// configuration register
	// ***************************************************
	logic wr_cfg, wr_cmd, wr_ists, wr_imsk;

	// only byte lane 0 carries register bits; upper lanes are ignored
	assign wr_cfg = wr_stb && wr_strb[0] && wr_addr == ADDR_CFG;
	assign wr_cmd = wr_stb && wr_strb[0] && wr_addr == ADDR_CMD;
	assign wr_ists = wr_stb && wr_strb[0] && wr_addr == ADDR_ISTS;
	assign wr_imsk = wr_stb && wr_strb[0] && wr_addr == ADDR_IMSK;
	// a wait-state write during a running command is dropped entirely
	assign ws_wr = wr_cfg && cmd_done_flag;

	// next values of the writable fields; bit 6 and bit 5 take no write data
	always_comb begin
		{irq_en_d, supp_d, ws_d, fdf_d, fsf_d} = {irq_en_q, supp_q, ws_q, fdf_q, fsf_q};
		if (wr_cfg) begin
			irq_en_d = wr_data[CFG_IRQEN_BIT];
			supp_d = wr_data[CFG_SUPP_BIT];
			fdf_d = wr_data[CFG_FDF_BIT];
			fsf_d = wr_data[CFG_FSF_BIT];
		end
		if (ws_wr) begin
			ws_d = wr_data[CFG_WS_LSB +: 2];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_en_q <= CFG_RESET[CFG_IRQEN_BIT];
			supp_q <= CFG_RESET[CFG_SUPP_BIT];
			ws_q <= CFG_RESET[CFG_WS_LSB +: 2];
			fdf_q <= CFG_RESET[CFG_FDF_BIT];
			fsf_q <= CFG_RESET[CFG_FSF_BIT];
		end else begin
			{irq_en_q, supp_q, ws_q, fdf_q, fsf_q} <= {irq_en_d, supp_d, ws_d, fdf_d, fsf_d};
		end
	end

	// ***************************************************
	// erase-all sequencer
	// ***************************************************
	fcr_state_t st_q, st_d;
	fcr_op_t op_q, op_d;
	logic pend_q, pend_d, start_q, start_d, unsec_q, unsec_d, er_prev_q, er_done;

	// the request input is edge-sensed so a held request runs only once
	always_comb begin
		st_d = st_q;
		op_d = op_q;
		pend_d = pend_q;
		start_d = 1'b0;
		unsec_d = 1'b0;
		er_done = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (erase_all_req && !er_prev_q && cmd_done_flag) begin
					pend_d = 1'b1;
					st_d = ST_ERASE;
					op_d = OP_ERASE_ALL;
					start_d = 1'b1;
				end
			end
			ST_ERASE: begin
				if (mc_step_done) begin
					st_d = ST_VERIFY;
					op_d = OP_VERIFY;
					start_d = 1'b1;
				end
			end
			ST_VERIFY: begin
				if (mc_step_done) begin
					st_d = ST_PROG;
					op_d = OP_PROG_SEC;
					start_d = 1'b1;
				end
			end
			ST_PROG: begin
				if (mc_step_done) begin
					st_d = ST_IDLE;
					op_d = OP_NONE;
					unsec_d = 1'b1;
					pend_d = 1'b0;
					er_done = 1'b1;
				end
			end
			default: begin
				st_d = ST_IDLE;
				op_d = OP_NONE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= ST_IDLE;
			op_q <= OP_NONE;
			{pend_q, start_q, unsec_q, er_prev_q} <= 4'h0;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			{pend_q, start_q, unsec_q, er_prev_q} <= {pend_d, start_d, unsec_d, erase_all_req};
		end
	end

	assign mc_op_start = start_q;
	assign mc_op_code = op_q;
	assign sec_force_unsecure = unsec_q;

	// ***************************************************
	// command launch and interrupts
	// ***************************************************
	logic launch_q, launch_d, done_prev_q, irq_q, irq_d;
	logic [EV_N-1:0] sts_q, sts_d, msk_q, msk_d, ev, gate;

	// launch only from the idle state; a one while busy has no effect
	assign launch_d = wr_cmd && wr_data[CMD_DONE_BIT] && cmd_done_flag;

	// events; the single-fault event is already filtered by the suppress bit
	assign ev[EV_CMD_DONE] = cmd_done_flag && !done_prev_q;
	assign ev[EV_SINGLE] = single_fault_set;
	assign ev[EV_DOUBLE] = double_fault_set;
	assign ev[EV_ERASE_DONE] = er_done;
	assign gate = {2'h3, single_fault_irq_enable, 1'b1};

	// sticky bits: write one clears, a same-cycle event wins
	always_comb begin
		sts_d = sts_q;
		msk_d = msk_q;
		if (wr_ists) begin
			sts_d = sts_q & ~wr_data[EV_N-1:0];
		end
		sts_d = sts_d | ev;
		if (wr_imsk) begin
			msk_d = wr_data[EV_N-1:0];
		end
		irq_d = (irq_en_q && cmd_done_flag) || |(sts_q & msk_q & gate);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sts_q <= '0;
			msk_q <= IMSK_RESET;
			{launch_q, done_prev_q, irq_q} <= 3'h0;
		end else begin
			sts_q <= sts_d;
			msk_q <= msk_d;
			{launch_q, done_prev_q, irq_q} <= {launch_d, cmd_done_flag, irq_d};
		end
	end

	assign cmd_launch = launch_q;
	assign irq = irq_q;

	// ***************************************************
	// read decode
	// ***************************************************
	// bit 6 and all bits above the byte stay zero
	always_comb begin
		rd_data = 32'h0;
		case (s_axi_araddr)
			ADDR_CFG: begin
				rd_data[CFG_IRQEN_BIT] = irq_en_q;
				rd_data[CFG_PEND_BIT] = pend_q;
				rd_data[CFG_SUPP_BIT] = supp_q;
				rd_data[CFG_WS_LSB +: 2] = ws_q;
				rd_data[CFG_FDF_BIT] = fdf_q;
				rd_data[CFG_FSF_BIT] = fsf_q;
			end
			ADDR_CMD: begin
				rd_data[CMD_DONE_BIT] = cmd_done_flag;
				rd_data[CMD_ACK_BIT] = wait_switch_ack;
			end
			ADDR_ISTS: rd_data[EV_N-1:0] = sts_q;
			ADDR_IMSK: rd_data[EV_N-1:0] = msk_q;
			default: rd_data = 32'h0;
		endcase
	end

	// ***************************************************
	// checks
	// ***************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	cmd_irq_req_a: assert property (irq_en_q && cmd_done_flag |=> irq)
		else $error("command-done interrupt missing");
	pend_ro_a: assert property ($rose(pend_q) |-> $past(st_q == ST_IDLE && erase_all_req))
		else $error("pending bit set without erase-all request");
	rsvd_zero_a: assert property (s_axi_araddr == ADDR_CFG |-> rd_data[31:8] == 24'h0
		&& !rd_data[6])
		else $error("reserved configuration bit reads nonzero");
	pend_set_a: assert property (st_q == ST_IDLE && erase_all_req && !er_prev_q
		&& cmd_done_flag |=> pend_q && mc_op_start && mc_op_code == OP_ERASE_ALL)
		else $error("erase-all sequence did not start");
	seq_order_a: assert property (st_q == ST_ERASE && mc_step_done
		|=> mc_op_start && mc_op_code == OP_VERIFY ##1 !mc_op_start)
		else $error("verify step did not follow erase");
	pend_clear_a: assert property (st_q == ST_PROG && mc_step_done
		|=> !pend_q && sec_force_unsecure ##1 !sec_force_unsecure)
		else $error("pending bit not cleared at sequence end");
	supp_single_a: assert property (single_fault_set |-> $past(!supp_q, 1))
		else $error("suppressed single fault reported");
	ws_reset_a: assert property ($rose(aresetn) |-> ws_q == WS_MAX)
		else $error("wait-state field not maximum after reset");
	ws_busy_a: assert property (wr_cfg && !cmd_done_flag |=> $stable(ws_q))
		else $error("wait-state field changed during a command");
	ws_rdback_a: assert property (ws_wr |=> ws_q == $past(wr_data[CFG_WS_LSB +: 2]))
		else $error("wait-state code not kept as written");
	force_dbl_a: assert property (rd_done && $past(fdf_q, 2) && $past(fdf_q)
		|-> double_fault_set)
		else $error("forced double fault not flagged");
	force_sgl_a: assert property (rd_done && $past(fsf_q) && !$past(supp_q)
		|-> single_fault_set)
		else $error("forced single fault not flagged");
	ws_ack_a: assert property (ws_wr |=> !wait_switch_ack)
		else $error("wait switch ack not cleared by write");
	launch_a: assert property (wr_cmd && wr_data[CMD_DONE_BIT] && cmd_done_flag
		|=> cmd_launch ##1 !cmd_launch)
		else $error("command launch pulse wrong");

	erase_seq_c: cover property (pend_q ##[1:40] sec_force_unsecure);
	irq_c: cover property ($rose(irq));
	ws_switch_c: cover property (ws_wr ##[1:20] wait_switch_ack);
	fault_c: cover property (single_fault_set && double_fault_set);
endmodule : fcr_top

// ==== testbench/fcr_top_test.sv ====
module fcr_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import fcr_pkg::*;
	// ************************************
	// bench signals and design instance
	// ************************************
	// wait count raised above one so the three waiting codes, which all share it, stand clear of the disabled code 3
	localparam int MW = 3;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic cmd_done_flag = 1'b1, erase_all_req = 1'b0, mc_step_done = 1'b0, rd_start = 1'b0;
	logic ecc_single = 1'b0, ecc_double = 1'b0, single_fault_irq_enable = 1'b0;
	logic irq, cmd_launch, mc_op_start, sec_force_unsecure, rd_done;
	logic single_fault_set, double_fault_set;
	fcr_op_t mc_op_code;
	int error_cnt = 0, compares = 0, launches = 0, unsecures = 0;
	int i;
	logic [7:0] tcfg [5] = '{8'h0d, 8'h0e, 8'h1c, 8'h0c, 8'h0c};
	logic [3:0] tecc [5] = '{4'b0010, 4'b0001, 4'b1000, 4'b1010, 4'b0101};

	fcr_top #(.MAX_WAIT(MW)) fcr_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd_done_flag,
		.erase_all_req, .mc_step_done, .rd_start, .ecc_single, .ecc_double,
		.single_fault_irq_enable, .irq, .cmd_launch, .mc_op_start, .mc_op_code,
		.sec_force_unsecure, .rd_done, .single_fault_set, .double_fault_set);

	always #2.5 aclk = ~aclk;

	// pulses are counted here since they stand for one cycle only
	always @(posedge aclk) begin
		if (cmd_launch === 1'b1) launches <= launches + 1;
		if (sec_force_unsecure === 1'b1) unsecures <= unsecures + 1;
	end

	// ************************************
	// access tasks and comparison
	// ************************************
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic tally_and_finish;
		if (error_cnt == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	// address and data offered together, each released at its own handshake
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic aw_p, w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_bvalid === 1'b1 && !aw_p && !w_p) break;
			if (aw_p && s_axi_awready === 1'b1) begin
				aw_p = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_p && s_axi_wready === 1'b1) begin
				w_p = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_rvalid === 1'b1) break;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end
		chk("rdata", ed, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	// one array read: cycles from the taking edge to rd_done, plus fault pulses
	task automatic arr_read(input logic [3:0] e, input int exp_n);
		int n;
		@(posedge aclk);
		rd_start <= 1'b1;
		ecc_single <= e[3];
		ecc_double <= e[2];
		@(posedge aclk);
		rd_start <= 1'b0;
		for (n = 1; n < 20; n++) begin
			@(posedge aclk);
			if (rd_done === 1'b1) break;
		end
		chk("rd_cycles", 32'(exp_n), 32'(n));
		chk("single_set", {31'h0, e[1]}, {31'h0, single_fault_set});
		chk("double_set", {31'h0, e[0]}, {31'h0, double_fault_set});
		ecc_single <= 1'b0;
		ecc_double <= 1'b0;
	endtask : arr_read

	// controller side: wait for a step start, check its code, report it finished
	task automatic mc_step(input fcr_op_t code);
		int n;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (mc_op_start === 1'b1) break;
		end
		chk("op_code", {30'h0, code}, {30'h0, mc_op_code});
		if (code == OP_ERASE_ALL) axi_rd(ADDR_CFG, 32'h20, RESP_OKAY);
		mc_step_done <= 1'b1;
		@(posedge aclk);
		mc_step_done <= 1'b0;
	endtask : mc_step

	// ************************************
	// test sequence and watchdog
	// ************************************
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(ADDR_CFG, 32'h0, RESP_OKAY);
		axi_rd(8'h20, 32'h0, RESP_SLVERR);
		axi_wr(8'h20, 32'hffff_ffff, RESP_SLVERR);
		axi_wr(ADDR_CFG, 32'hffff_ffff, RESP_OKAY);
		axi_rd(ADDR_CFG, 32'h9f, RESP_OKAY);
		chk("irq_on", 32'h1, {31'h0, irq});
		cmd_done_flag <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("irq_off", 32'h0, {31'h0, irq});
		axi_wr(ADDR_CFG, 32'h04, RESP_OKAY);
		axi_rd(ADDR_CFG, 32'h0c, RESP_OKAY);
		cmd_done_flag <= 1'b1;
		// every wait code, reserved ones included, with its read timing and ack
		for (i = 0; i < 4; i++) begin
			axi_wr(ADDR_CFG, 32'(i) << 2, RESP_OKAY);
			axi_rd(ADDR_CFG, 32'(i) << 2, RESP_OKAY);
			arr_read(4'b0000, (i == 3) ? 2 : 2 + MW);
			axi_rd(ADDR_CMD, 32'h81, RESP_OKAY);
		end
		// forced faults, suppression and real ECC results
		for (i = 0; i < 5; i++) begin
			axi_wr(ADDR_CFG, {24'h0, tcfg[i]}, RESP_OKAY);
			arr_read(tecc[i], 2);
		end
		axi_wr(ADDR_ISTS, 32'hf, RESP_OKAY);
		axi_wr(ADDR_IMSK, 32'h2, RESP_OKAY);
		single_fault_irq_enable <= 1'b1;
		axi_wr(ADDR_CFG, 32'h0d, RESP_OKAY);
		arr_read(4'b0010, 2);
		repeat (2) @(posedge aclk);
		chk("irq_fault", 32'h1, {31'h0, irq});
		axi_rd(ADDR_ISTS, 32'h2, RESP_OKAY);
		axi_wr(ADDR_ISTS, 32'h2, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("irq_clear", 32'h0, {31'h0, irq});
		axi_wr(ADDR_CFG, 32'h0, RESP_OKAY);
		axi_wr(ADDR_CMD, 32'h80, RESP_OKAY);
		// the pulse counter updates at the edge the write returns on
		@(posedge aclk);
		chk("launch", 32'h1, 32'(launches));
		// full erase-all sequence driven from the system input
		@(posedge aclk);
		erase_all_req <= 1'b1;
		mc_step(OP_ERASE_ALL);
		mc_step(OP_VERIFY);
		mc_step(OP_PROG_SEC);
		repeat (3) @(posedge aclk);
		chk("unsecure", 32'h1, 32'(unsecures));
		axi_rd(ADDR_CFG, 32'h0, RESP_OKAY);
		axi_rd(ADDR_ISTS, 32'h8, RESP_OKAY);
		erase_all_req <= 1'b0;
		tally_and_finish();
	end

	// far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		tally_and_finish();
	end
endmodule : fcr_top_test
